// ===== design/cmp_irq_pkg.sv
// Constants for the low-input comparator edge interrupt selection block.
// Assumes one 250 MHz clock and an AHB-Lite register bus.
package cmp_irq_pkg;

    // Channel layout
    localparam int CHANNELS = 12;
    localparam int GROUP_SIZE = 4;
    localparam int GROUPS = 3;
    localparam int CODE_W = 2;
    localparam int SEL_W = 24;
    localparam int THR_W = 6;
    localparam int LEVEL_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [9:0] THR_INDEX = 10'h021;
    localparam logic [9:0] SEL_INDEX = 10'h022;
    localparam logic [9:0] STATE_INDEX = 10'h040;

    // Reset values
    localparam logic [SEL_W-1:0] SEL_RESET = 24'h000000;
    localparam logic [THR_W-1:0] THR_RESET = 6'h00;

    // Edge selection codes
    localparam logic [CODE_W-1:0] EDGE_NONE = 2'h0;
    localparam logic [CODE_W-1:0] EDGE_RISE = 2'h1;
    localparam logic [CODE_W-1:0] EDGE_FALL = 2'h2;
    localparam logic [CODE_W-1:0] EDGE_BOTH = 2'h3;

    // Threshold codes and voltages, level samples in 100 mV steps
    localparam logic [CODE_W-1:0] THR_CODE_2V0 = 2'h0;
    localparam logic [CODE_W-1:0] THR_CODE_2V7 = 2'h1;
    localparam logic [CODE_W-1:0] THR_CODE_3V0 = 2'h2;
    localparam logic [CODE_W-1:0] THR_CODE_4V0 = 2'h3;
    localparam int LSB_MV = 100;
    localparam int THR_2V0_MV = 2000;
    localparam int THR_2V7_MV = 2700;
    localparam int THR_3V0_MV = 3000;
    localparam int THR_4V0_MV = 4000;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : cmp_irq_pkg

// ===== design/thr_decode.sv
// Maps a two-bit comparator threshold code to a level reference.
// Assumes level samples in the package's 100 mV steps.
module thr_decode
#(
    parameter int LW = cmp_irq_pkg::LEVEL_W
)
(
    // Code in, reference out
    input wire logic [cmp_irq_pkg::CODE_W-1:0] code_i,
    output logic [LW-1:0] ref_o
);

    always_comb
    begin
        case (code_i)
            cmp_irq_pkg::THR_CODE_2V0:
                ref_o = LW'(cmp_irq_pkg::THR_2V0_MV / cmp_irq_pkg::LSB_MV);
            cmp_irq_pkg::THR_CODE_2V7:
                ref_o = LW'(cmp_irq_pkg::THR_2V7_MV / cmp_irq_pkg::LSB_MV);
            cmp_irq_pkg::THR_CODE_3V0:
                ref_o = LW'(cmp_irq_pkg::THR_3V0_MV / cmp_irq_pkg::LSB_MV);
            default:
                ref_o = LW'(cmp_irq_pkg::THR_4V0_MV / cmp_irq_pkg::LSB_MV);
        endcase
    end

endmodule : thr_decode

// ===== design/chan_edge_detect.sv
// One channel: threshold compare, previous-sample memory, edge select.
// Assumes samples and their strobe come from logic on the same clock.
module chan_edge_detect
#(
    parameter int LW = cmp_irq_pkg::LEVEL_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Sample and configuration
    input wire logic [LW-1:0] level_i,
    input wire logic [LW-1:0] ref_i,
    input wire logic [cmp_irq_pkg::CODE_W-1:0] sel_i,
    input wire logic valid_i,
    // Results
    output logic above_o,
    output logic event_o
);

    logic above_now;
    logic primed_r;
    logic rise;
    logic fall;

    assign above_now = (level_i > ref_i);

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            above_o <= 1'b0;
            primed_r <= 1'b0;
        end
        else if (valid_i)
        begin
            above_o <= above_now;
            primed_r <= 1'b1;
        end
    end

    assign rise = valid_i && primed_r && above_now && !above_o;
    assign fall = valid_i && primed_r && !above_now && above_o;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            event_o <= 1'b0;
        else
        begin
            case (sel_i)
                cmp_irq_pkg::EDGE_RISE: event_o <= rise;
                cmp_irq_pkg::EDGE_FALL: event_o <= fall;
                cmp_irq_pkg::EDGE_BOTH: event_o <= rise || fall;
                default: event_o <= 1'b0;
            endcase
        end
    end

    property p_none;
        @(posedge ref_clk_i) disable iff (rst_i)
        sel_i == cmp_irq_pkg::EDGE_NONE |=> !event_o;
    endproperty
    a_none: assert property (p_none)
        else $error("event raised with code zero");

    property p_rise;
        @(posedge ref_clk_i) disable iff (rst_i)
        sel_i == cmp_irq_pkg::EDGE_RISE
            |=> event_o == ($rose(above_o) && $past(primed_r));
    endproperty
    a_rise: assert property (p_rise)
        else $error("rise select mismatch");

    property p_fall;
        @(posedge ref_clk_i) disable iff (rst_i)
        (sel_i == cmp_irq_pkg::EDGE_FALL && valid_i && primed_r
            && above_o && level_i <= ref_i) |=> event_o;
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling crossing missed");

    property p_both;
        @(posedge ref_clk_i) disable iff (rst_i)
        (sel_i == cmp_irq_pkg::EDGE_BOTH && valid_i && primed_r)
            |=> event_o == $changed(above_o);
    endproperty
    a_both: assert property (p_both)
        else $error("both-edge select mismatch");

    property p_one_per_change;
        @(posedge ref_clk_i) disable iff (rst_i)
        !valid_i |=> !event_o;
    endproperty
    a_one_per_change: assert property (p_one_per_change)
        else $error("event without a new sample");

endmodule : chan_edge_detect

// ===== design/comparator_edge_irq_select_low.sv
// Comparator edge interrupt selection for inputs 0 to 11, AHB-Lite slave.
// Assumes level samples arrive with a strobe from logic on ref_clk_i.
module comparator_edge_irq_select_low
#(
    parameter int CH = cmp_irq_pkg::CHANNELS,
    parameter int LW = cmp_irq_pkg::LEVEL_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Comparator samples
    input wire logic [CH*LW-1:0] level_i,
    input wire logic sample_valid_i,
    // Results
    output logic [CH-1:0] irq_event_o,
    output logic [CH-1:0] comp_above_o
);

    localparam int GR = cmp_irq_pkg::GROUPS;
    localparam int GS = cmp_irq_pkg::GROUP_SIZE;
    localparam int CW = cmp_irq_pkg::CODE_W;

    // Bus phase tracking
    logic addr_take;
    logic dphase_r;
    logic dwrite_r;
    logic dword_r;
    logic [9:0] dindex_r;
    logic [9:0] aindex;

    // Registers
    logic [cmp_irq_pkg::SEL_W-1:0] sel_r;
    logic [cmp_irq_pkg::SEL_W-1:0] sel_nxt;
    logic [cmp_irq_pkg::THR_W-1:0] thr_r;
    logic [cmp_irq_pkg::THR_W-1:0] thr_nxt;
    logic wr_sel;
    logic wr_thr;
    logic [31:0] rdata_nxt;

    // Per-group references
    logic [LW-1:0] group_ref [GR];

    assign aindex = haddr_i[11:2];
    assign addr_take = hsel_i && hready_i
        && (htrans_i == cmp_irq_pkg::HTRANS_NONSEQ);

    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = cmp_irq_pkg::HRESP_OKAY;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dphase_r <= 1'b0;
            dwrite_r <= 1'b0;
            dword_r <= 1'b0;
            dindex_r <= 10'h000;
        end
        else if (hready_i)
        begin
            dphase_r <= addr_take;
            dwrite_r <= addr_take && hwrite_i;
            dword_r <= (hsize_i == cmp_irq_pkg::HSIZE_WORD);
            dindex_r <= aindex;
        end
    end

    // Word writes only; narrower ones are ignored
    assign wr_sel = dphase_r && dwrite_r && dword_r
        && (dindex_r == cmp_irq_pkg::SEL_INDEX);
    assign wr_thr = dphase_r && dwrite_r && dword_r
        && (dindex_r == cmp_irq_pkg::THR_INDEX);

    always_comb
    begin
        sel_nxt = sel_r;
        thr_nxt = thr_r;
        if (wr_sel)
            sel_nxt = hwdata_i[cmp_irq_pkg::SEL_W-1:0];
        if (wr_thr)
            thr_nxt = hwdata_i[cmp_irq_pkg::THR_W-1:0];
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            sel_r <= cmp_irq_pkg::SEL_RESET;
        else
            sel_r <= sel_nxt;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            thr_r <= cmp_irq_pkg::THR_RESET;
        else
            thr_r <= thr_nxt;
    end

    // read mux, forwarded from a write in flight
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        case (aindex)
            cmp_irq_pkg::SEL_INDEX:
                rdata_nxt[cmp_irq_pkg::SEL_W-1:0] = sel_nxt;
            cmp_irq_pkg::THR_INDEX:
                rdata_nxt[cmp_irq_pkg::THR_W-1:0] = thr_nxt;
            cmp_irq_pkg::STATE_INDEX:
                rdata_nxt[CH-1:0] = comp_above_o;
            default:
                rdata_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            hrdata_o <= 32'h00000000;
        else if (addr_take && !hwrite_i)
            hrdata_o <= rdata_nxt;
    end

    generate
        for (genvar g = 0; g < GR; g++)
        begin : g_group
            thr_decode #(
                .LW(LW)
            ) u_dec (
                .code_i(thr_r[g*CW +: CW]),
                .ref_o(group_ref[g])
            );
        end
    endgenerate

    // channel n takes code pair n and group n/4
    generate
        for (genvar n = 0; n < CH; n++)
        begin : g_chan
            chan_edge_detect #(
                .LW(LW)
            ) u_chan (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .level_i(level_i[n*LW +: LW]),
                .ref_i(group_ref[n / GS]),
                .sel_i(sel_r[n*CW +: CW]),
                .valid_i(sample_valid_i),
                .above_o(comp_above_o[n]),
                .event_o(irq_event_o[n])
            );
        end
    endgenerate

    // Helper: any write to the selection register seen since reset
    logic wr_seen_r;
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            wr_seen_r <= 1'b0;
        else if (wr_sel)
            wr_seen_r <= 1'b1;
    end

    property p_reset_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        !wr_seen_r |-> (sel_r == cmp_irq_pkg::SEL_RESET && irq_event_o == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("selection not zero before first write");

    property p_field_place;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_sel |=> sel_r[23:22] == $past(hwdata_i[23:22])
            && sel_r[1:0] == $past(hwdata_i[1:0]);
    endproperty
    a_field_place: assert property (p_field_place)
        else $error("selection field landed in the wrong bits");

    property p_readback;
        @(posedge ref_clk_i) disable iff (rst_i)
        (addr_take && !hwrite_i && aindex == cmp_irq_pkg::SEL_INDEX)
            |=> hrdata_o == {8'h00, sel_r};
    endproperty
    a_readback: assert property (p_readback)
        else $error("selection readback differs from stored value");

    property p_group_ref;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_thr && hwdata_i[5:4] == cmp_irq_pkg::THR_CODE_4V0
            |=> group_ref[2] ==
                LW'(cmp_irq_pkg::THR_4V0_MV / cmp_irq_pkg::LSB_MV)
            && thr_r[5:4] == cmp_irq_pkg::THR_CODE_4V0;
    endproperty
    a_group_ref: assert property (p_group_ref)
        else $error("upper group reference not taken from its field");

    property p_thr_2v7;
        @(posedge ref_clk_i) disable iff (rst_i)
        thr_r[3:2] == cmp_irq_pkg::THR_CODE_2V7 |->
            group_ref[1] ==
                LW'(cmp_irq_pkg::THR_2V7_MV / cmp_irq_pkg::LSB_MV);
    endproperty
    a_thr_2v7: assert property (p_thr_2v7)
        else $error("threshold code 1 not decoded to 2.7 V");

    property p_thr_2v0;
        @(posedge ref_clk_i) disable iff (rst_i)
        thr_r[1:0] == cmp_irq_pkg::THR_CODE_2V0 |->
            group_ref[0] == LW'(cmp_irq_pkg::THR_2V0_MV / cmp_irq_pkg::LSB_MV);
    endproperty
    a_thr_2v0: assert property (p_thr_2v0)
        else $error("threshold code 0 not decoded to 2 V");

    property p_thr_3v0;
        @(posedge ref_clk_i) disable iff (rst_i)
        thr_r[5:4] == cmp_irq_pkg::THR_CODE_3V0 |->
            group_ref[2] == LW'(cmp_irq_pkg::THR_3V0_MV / cmp_irq_pkg::LSB_MV);
    endproperty
    a_thr_3v0: assert property (p_thr_3v0)
        else $error("threshold code 2 not decoded to 3 V");

    property p_sel_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        !wr_sel |=> sel_r == $past(sel_r);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("selection changed without a write");

    property p_thr_store;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_thr |=> thr_r == $past(hwdata_i[cmp_irq_pkg::THR_W-1:0]);
    endproperty
    a_thr_store: assert property (p_thr_store)
        else $error("threshold write not stored");

    property p_thr_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        !wr_thr |=> thr_r == $past(thr_r);
    endproperty
    a_thr_hold: assert property (p_thr_hold)
        else $error("threshold changed without a write");

    property p_thr_readback;
        @(posedge ref_clk_i) disable iff (rst_i)
        (addr_take && !hwrite_i && aindex == cmp_irq_pkg::THR_INDEX)
            |=> hrdata_o == 32'(thr_r);
    endproperty
    a_thr_readback: assert property (p_thr_readback)
        else $error("threshold readback differs from stored value");

    property p_unmapped_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        (addr_take && !hwrite_i && aindex != cmp_irq_pkg::SEL_INDEX
            && aindex != cmp_irq_pkg::THR_INDEX
            && aindex != cmp_irq_pkg::STATE_INDEX) |=> hrdata_o == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned nonzero data");

    property p_state_read;
        @(posedge ref_clk_i) disable iff (rst_i)
        (addr_take && !hwrite_i && aindex == cmp_irq_pkg::STATE_INDEX)
            |=> hrdata_o == 32'($past(comp_above_o));
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("state readback differs from compare flags");

    generate
        for (genvar n = 0; n < CH; n++)
        begin : g_chk
            property p_above_set;
                @(posedge ref_clk_i) disable iff (rst_i)
                sample_valid_i && level_i[n*LW +: LW] > group_ref[n / GS]
                    |=> comp_above_o[n];
            endproperty
            a_above_set: assert property (p_above_set)
                else $error("compare flag not set above group reference");
            property p_above_clr;
                @(posedge ref_clk_i) disable iff (rst_i)
                sample_valid_i && level_i[n*LW +: LW] <= group_ref[n / GS]
                    |=> !comp_above_o[n];
            endproperty
            a_above_clr: assert property (p_above_clr)
                else $error("compare flag set at or below group reference");
        end
    endgenerate

endmodule : comparator_edge_irq_select_low

// ===== verification/comparator_edge_irq_select_low_tb.sv
// Self-checking bench for the low-input comparator edge selection block.
// Assumes the design package is compiled first; bench drives all ports.
module comparator_edge_irq_select_low_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] SEL_A = 32'({cmp_irq_pkg::SEL_INDEX, 2'h0});
    localparam logic [31:0] THR_A = 32'({cmp_irq_pkg::THR_INDEX, 2'h0});
    localparam logic [95:0] HI = {12{8'h32}};

    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic hready_i;
    logic hreadyout_o;
    logic hresp_o;
    logic [31:0] hrdata_o;
    logic [95:0] level_i = 96'h0;
    logic sample_valid_i = 1'b0;
    logic [11:0] irq_event_o;
    logic [11:0] comp_above_o;
    int err_count = 0;
    int checks = 0;
    logic [31:0] rd;
    logic [31:0] sel_v = 32'h0;
    logic [95:0] lv1;
    logic [95:0] lv2;
    logic [11:0] ev_m;
    logic [11:0] ab1;
    logic [11:0] ab2;
    // Rows, one per channel: code, first level, second level, event
    logic [1:0] r_code [12] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3,
                                2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [7:0] r_l1 [12] = '{8'h14, 8'h15, 8'h15, 8'h14, 8'h1b, 8'h1c,
                              8'h1b, 8'h1c, 8'h1e, 8'h1e, 8'h29, 8'h2d};
    logic [7:0] r_l2 [12] = '{8'h15, 8'h14, 8'h14, 8'h15, 8'h1c, 8'h1b,
                              8'h1c, 8'h14, 8'h29, 8'h27, 8'h28, 8'h23};
    logic r_ev [12] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
                        1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    // Group references for threshold field value 6'h34
    int ref_lv [3] = '{cmp_irq_pkg::THR_2V0_MV / cmp_irq_pkg::LSB_MV,
                       cmp_irq_pkg::THR_2V7_MV / cmp_irq_pkg::LSB_MV,
                       cmp_irq_pkg::THR_4V0_MV / cmp_irq_pkg::LSB_MV};

    assign hready_i = hreadyout_o;

    comparator_edge_irq_select_low uut
    (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .hrdata_o(hrdata_o),
        .level_i(level_i),
        .sample_valid_i(sample_valid_i),
        .irq_event_o(irq_event_o),
        .comp_above_o(comp_above_o)
    );

    always #2 ref_clk_i = ~ref_clk_i;

    task automatic stop_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= cmp_irq_pkg::HTRANS_NONSEQ;
        haddr_i <= a;
        hwrite_i <= w;
        hsize_i <= cmp_irq_pkg::HSIZE_WORD;
        do @(posedge ref_clk_i); while (hready_i !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge ref_clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
        chk(32'(hresp_o), 32'(cmp_irq_pkg::HRESP_OKAY));
    endtask : bus

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc

    // One strobe; events and compare flags seen the cycle after
    task automatic smp(input logic [95:0] lv, input logic [11:0] ev,
                       input logic [11:0] ab);
        @(posedge ref_clk_i);
        level_i <= lv;
        sample_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b0;
        #1;
        chk(32'(irq_event_o), 32'(ev));
        chk(32'(comp_above_o), 32'(ab));
    endtask : smp

    // Two strobes on consecutive edges, then the pulse must drop
    task automatic bb(input logic [95:0] a, input logic [95:0] b);
        @(posedge ref_clk_i);
        level_i <= a;
        sample_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        level_i <= b;
        #1;
        chk(32'(irq_event_o), 32'hfff);
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b0;
        #1;
        chk(32'(irq_event_o), 32'hfff);
        @(posedge ref_clk_i);
        #1;
        chk(32'(irq_event_o), 32'h0);
    endtask : bb

    initial
    begin
        #20000;
        err_count++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk(32'(irq_event_o | comp_above_o), 32'h0);
        rdc(SEL_A, 32'h0);
        rdc(THR_A, 32'h0);
        bus(1'b1, THR_A, 32'h34);
        rdc(THR_A, 32'h34);
        for (int n = 0; n < 12; n++)
        begin
            sel_v[2*n +: 2] = r_code[n];
            lv1[8*n +: 8] = r_l1[n];
            lv2[8*n +: 8] = r_l2[n];
            ev_m[n] = r_ev[n];
            ab1[n] = r_l1[n] > ref_lv[n/4];
            ab2[n] = r_l2[n] > ref_lv[n/4];
        end
        bus(1'b1, SEL_A, sel_v);
        rdc(SEL_A, sel_v);
        smp(lv1, 12'h0, ab1);
        smp(lv2, ev_m, ab2);
        smp(lv2, 12'h0, ab2);
        bus(1'b1, SEL_A, 32'hffffffff);
        rdc(SEL_A, 32'h00ffffff);
        smp(96'h0, ab2, 12'h0);
        bb(HI, 96'h0);
        @(posedge ref_clk_i);
        level_i <= HI;
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk(32'(irq_event_o | comp_above_o), 32'h0);
        bus(1'b1, SEL_A, 32'h0);
        smp(HI, 12'h0, 12'hfff);
        rdc(32'h90, 32'h0);
        // All groups at code 2: reference sits at exactly 3 V
        bus(1'b1, THR_A, 32'h2a);
        rdc(THR_A, 32'h2a);
        smp({12{8'h1f}}, 12'h0, 12'hfff);
        rdc(32'h100, 32'hfff);
        smp({12{8'h1e}}, 12'h0, 12'h0);
        rdc(32'h100, 32'h0);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk(32'(irq_event_o | comp_above_o), 32'h0);
        rdc(SEL_A, 32'h0);
        rdc(THR_A, 32'h0);
        bus(1'b1, SEL_A, 32'h00ffffff);
        // First sample after reset only primes, even above the reference
        smp(HI, 12'h0, 12'hfff);
        stop_test();
    end
endmodule : comparator_edge_irq_select_low_tb
